// File: mic_defs.vh
// Constants of the interrupt controller: register map, fields, resets, vectors
// Overview of operation
// - Every comparator, timer and peripheral event sets its request flag, whatever the enables hold; a pin event needs its pin enable.
// - A set flag causes a vector jump only while its own enable is one.
// - Global enable at zero blocks every interrupt.
// - On acceptance push the next-instruction address, then load and fetch the vector.
// - Return-from-interrupt pops the saved address so execution resumes.
// - Servicing any interrupt clears the global enable, preventing nesting.
// - Requests arriving while blocked still set and hold their flags.
// - A full stack blocks acknowledgement until the stack pointer drops.
// - A newly set flag wakes from sleep or idle; an old one does not.
// - Each external pin sets its flag on the edge its select chooses.
// - Edge select offers rising, falling, both, or disabled per pin.
// - A pin acts as interrupt input only when enabled and set as input.
// - Servicing an external pin interrupt clears that pin flag and global enable.
// - Pull-high selection on interrupt pins stays in effect.
// - Each comparator sets its flag whenever its output changes state.
// - Servicing a comparator interrupt clears its flag and the global enable.
// - Peripheral group register: flags in bits 7..4, enables 3..0, reset zero.
// - Timer one register: A,P flags bits 5,4, enables 1,0; B at 6 and 2.
// - Timer three register: A,P flags bits 5,4, enables bits 1,0, reset zero.
// - Unimplemented bits of these registers always read zero.
// - Single sources own vectors; grouped sources share a multi-function vector.
// - A multi-function flag sets when any grouped source whose own enable is one raises its flag.
// - Servicing clears only the multi-function flag; software clears source flags.
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH
`define MIC_AW 8
`define MIC_PC_W 13
// Register byte offsets
`define MIC_OFS_CORE 8'h00
`define MIC_OFS_EXT 8'h04
`define MIC_OFS_EDGE 8'h08
`define MIC_OFS_CMP 8'h0C
`define MIC_OFS_TM1X 8'h10
`define MIC_OFS_TM1B 8'h14
`define MIC_OFS_PER 8'h18
`define MIC_OFS_TM3 8'h1C
`define MIC_OFS_MF 8'h20
`define MIC_OFS_PULL 8'h24
`define MIC_OFS_STAT 8'h28
// Implemented bit masks
`define MIC_MSK_CORE 8'h01
`define MIC_MSK_EXT 8'hFF
`define MIC_MSK_CMP 8'h33
`define MIC_MSK_TM1X 8'h77
`define MIC_MSK_TM1B 8'h33
`define MIC_MSK_PER 8'hFF
`define MIC_MSK_TM3 8'h33
`define MIC_MSK_MF 8'h77
`define MIC_MSK_PULL 8'h0F
`define MIC_RST_BYTE 8'h00
// Field positions
`define MIC_FLAG_LSB 4
`define MIC_GE_BIT 0
// Edge select codes
`define MIC_EDGE_OFF 2'b00
`define MIC_EDGE_RISE 2'b01
`define MIC_EDGE_FALL 2'b10
`define MIC_EDGE_BOTH 2'b11
// Vectors, lower address means higher priority
`define MIC_VEC_EXT0 13'h0004
`define MIC_VEC_EXT1 13'h0008
`define MIC_VEC_EXT2 13'h000C
`define MIC_VEC_EXT3 13'h0010
`define MIC_VEC_CMP0 13'h0014
`define MIC_VEC_CMP1 13'h0018
`define MIC_VEC_MF0 13'h001C
`define MIC_VEC_MF1 13'h0020
`define MIC_VEC_MF2 13'h0024
`define MIC_NSRC 9
// Bus responses
`define MIC_RESP_OKAY 2'b00
`define MIC_RESP_SLVERR 2'b10
`endif

// File: mic_edge_det.v
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_edge_det (
	input wire clk,
	input wire rst_n,
	input wire pin,
	input wire [1:0] mode,
	output wire evt
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	wire rise;
	wire fall;
	// Two stages against metastability, third stage for edge history
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// Edge type chosen by mode; off code never fires
	assign rise = s2_reg & ~s3_reg;
	assign fall = ~s2_reg & s3_reg;
	assign evt = (mode == `MIC_EDGE_RISE) ? rise :
		(mode == `MIC_EDGE_FALL) ? fall :
		(mode == `MIC_EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

// File: mic_prio.v
// Fixed priority picker, lowest index wins
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_prio (
	input wire [`MIC_NSRC-1:0] req,
	output reg hit,
	output reg [3:0] idx
);
	integer i;
	// Scan from the top so the lowest index lands last
	always @* begin
		hit = 1'b0;
		idx = 4'h0;
		for (i = `MIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				hit = 1'b1;
				idx = i[3:0];
			end
		end
	end
endmodule

// File: mic_top.v
// Interrupt controller with AXI4-Lite registers and core sequencing handshake
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_top (
	input wire MCLK,
	input wire ARST_N,
	input wire [`MIC_AW-1:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [`MIC_AW-1:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire [3:0] EXT_IRQ_PINS,
	input wire [3:0] PORT_DIR_IN,
	input wire EXT_PERIPH_PIN,
	input wire CMP0_OUT,
	input wire CMP1_OUT,
	input wire TM1_CMPA_EVT,
	input wire TM1_CMPP_EVT,
	input wire TM1_CMPB_EVT,
	input wire TM3_CMPA_EVT,
	input wire TM3_CMPP_EVT,
	input wire EEPROM_EVT,
	input wire LOW_VOLT_EVT,
	input wire SERIAL_EVT,
	input wire [`MIC_PC_W-1:0] PC_NEXT,
	input wire STACK_FULL,
	input wire ACCEPT_SLOT,
	input wire RETURN_FROM_INTERRUPT,
	input wire LOW_POWER,
	output wire IRQ_TAKE,
	output wire [`MIC_PC_W-1:0] VECTOR_ADDR,
	output wire PUSH_PC,
	output wire [`MIC_PC_W-1:0] PUSH_DATA,
	output wire POP_PC,
	output wire WAKE_UP,
	output wire [3:0] PULLUP_EN
);
	// Register file
	reg [7:0] core_reg;
	reg [7:0] ext_reg;
	reg [7:0] edge_reg;
	reg [7:0] cmp_reg;
	reg [7:0] tm1_reg;
	reg [7:0] per_reg;
	reg [7:0] tm3_reg;
	reg [7:0] mf_reg;
	reg [7:0] pull_reg;
	// Bus state
	reg aw_hold_reg;
	reg [`MIC_AW-1:0] awaddr_reg;
	reg w_hold_reg;
	reg [7:0] wdata_reg;
	reg wstrb0_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	// Core handshake outputs
	reg take_reg;
	reg [`MIC_PC_W-1:0] vector_reg;
	reg [`MIC_PC_W-1:0] push_data_reg;
	reg pop_reg;
	reg wake_reg;
	// Internal nets
	wire [3:0] pin_evt;
	wire [3:0] ext_evt;
	wire xp_evt;
	wire [1:0] cmp_evt;
	wire [`MIC_NSRC-1:0] pend;
	wire hit;
	wire [3:0] idx;
	wire take;
	wire [`MIC_NSRC-1:0] onehot;
	wire wr_fire;
	wire [2:0] mf_evt;
	wire [7:0] ext_set;
	wire [7:0] cmp_set;
	wire [7:0] tm1_set;
	wire [7:0] per_set;
	wire [7:0] tm3_set;
	wire [7:0] mf_set;
	wire [7:0] ext_clr;
	wire [7:0] cmp_clr;
	wire [7:0] mf_clr;
	wire new_flag;
	reg [31:0] rd_mux;
	genvar g;

	// Flag/enable byte update: write, then service clear, then hardware set wins
	function [7:0] upd;
		input [7:0] cur;
		input wr;
		input [7:0] wd;
		input [7:0] msk;
		input [7:0] set;
		input [7:0] clr;
		begin
			upd = ((((wr ? wd : cur) & ~clr) | set) & msk);
		end
	endfunction

	// Address is one of the mapped words
	function mapped;
		input [`MIC_AW-1:0] a;
		begin
			case (a)
				`MIC_OFS_CORE, `MIC_OFS_EXT, `MIC_OFS_EDGE, `MIC_OFS_CMP,
				`MIC_OFS_TM1X, `MIC_OFS_TM1B, `MIC_OFS_PER, `MIC_OFS_TM3,
				`MIC_OFS_MF, `MIC_OFS_PULL, `MIC_OFS_STAT: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	// Vector address of each source index
	function [`MIC_PC_W-1:0] vec_of;
		input [3:0] i;
		begin
			case (i)
				4'h0: vec_of = `MIC_VEC_EXT0;
				4'h1: vec_of = `MIC_VEC_EXT1;
				4'h2: vec_of = `MIC_VEC_EXT2;
				4'h3: vec_of = `MIC_VEC_EXT3;
				4'h4: vec_of = `MIC_VEC_CMP0;
				4'h5: vec_of = `MIC_VEC_CMP1;
				4'h6: vec_of = `MIC_VEC_MF0;
				4'h7: vec_of = `MIC_VEC_MF1;
				4'h8: vec_of = `MIC_VEC_MF2;
				default: vec_of = `MIC_VEC_EXT0;
			endcase
		end
	endfunction

	// External pins, each with its own edge selector
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_pin
			mic_edge_det u_pin (
				.clk(MCLK),
				.rst_n(ARST_N),
				.pin(EXT_IRQ_PINS[g]),
				.mode(edge_reg[2*g+1:2*g]),
				.evt(pin_evt[g])
			);
		end
	endgenerate

	// External peripheral pin fires on the falling edge only
	mic_edge_det u_xp (
		.clk(MCLK),
		.rst_n(ARST_N),
		.pin(EXT_PERIPH_PIN),
		.mode(`MIC_EDGE_FALL),
		.evt(xp_evt)
	);

	// Comparator outputs are asynchronous to MCLK; any change counts
	mic_edge_det u_cmp0 (
		.clk(MCLK),
		.rst_n(ARST_N),
		.pin(CMP0_OUT),
		.mode(`MIC_EDGE_BOTH),
		.evt(cmp_evt[0])
	);
	mic_edge_det u_cmp1 (
		.clk(MCLK),
		.rst_n(ARST_N),
		.pin(CMP1_OUT),
		.mode(`MIC_EDGE_BOTH),
		.evt(cmp_evt[1])
	);

	// Pin is an interrupt input only while enabled and set as input
	assign ext_evt = pin_evt & ext_reg[3:0] & PORT_DIR_IN;

	// Event sets, independent of the global enable; pin sets also need the pin enable
	assign ext_set = {ext_evt, 4'h0};
	assign cmp_set = {2'b00, cmp_evt, 4'h0};
	assign tm1_set = {1'b0, TM1_CMPB_EVT, TM1_CMPA_EVT, TM1_CMPP_EVT, 4'h0};
	assign per_set = {EEPROM_EVT, LOW_VOLT_EVT, xp_evt, SERIAL_EVT, 4'h0};
	assign tm3_set = {2'b00, TM3_CMPA_EVT, TM3_CMPP_EVT, 4'h0};

	// Grouped sources reach their shared flag only through their own enable
	assign mf_evt[0] = |(tm1_set[6:4] & tm1_reg[2:0]);
	assign mf_evt[1] = |(per_set[7:4] & per_reg[3:0]);
	assign mf_evt[2] = |(tm3_set[5:4] & tm3_reg[1:0]);
	assign mf_set = {1'b0, mf_evt, 4'h0};

	// Pending requests in priority order: pins, comparators, groups
	assign pend = {mf_reg[6:4] & mf_reg[2:0],
		cmp_reg[5:4] & cmp_reg[1:0],
		ext_reg[7:4] & ext_reg[3:0]};

	mic_prio u_prio (
		.req(pend),
		.hit(hit),
		.idx(idx)
	);

	// Acceptance needs global enable, a free stack and a sequencer slot
	assign take = core_reg[`MIC_GE_BIT] & hit & ~STACK_FULL & ACCEPT_SLOT;
	assign onehot = take ? ({{(`MIC_NSRC-1){1'b0}}, 1'b1} << idx) : {`MIC_NSRC{1'b0}};

	// Service clears only the serviced flag; group source flags stay for software
	assign ext_clr = {onehot[3:0], 4'h0};
	assign cmp_clr = {2'b00, onehot[5:4], 4'h0};
	assign mf_clr = {1'b0, onehot[8:6], 4'h0};

	// A flag going from clear to set is what wakes the core
	assign new_flag = |(ext_set & ~ext_reg) | |(cmp_set & ~cmp_reg) |
		|(tm1_set & ~tm1_reg) | |(per_set & ~per_reg) |
		|(tm3_set & ~tm3_reg) | |(mf_set & ~mf_reg);

	// Write happens once both address and data are held
	assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;

	// Register file update; basic timer-one view leaves comparator B untouched
	always @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			core_reg <= `MIC_RST_BYTE;
			ext_reg <= `MIC_RST_BYTE;
			edge_reg <= `MIC_RST_BYTE;
			cmp_reg <= `MIC_RST_BYTE;
			tm1_reg <= `MIC_RST_BYTE;
			per_reg <= `MIC_RST_BYTE;
			tm3_reg <= `MIC_RST_BYTE;
			mf_reg <= `MIC_RST_BYTE;
			pull_reg <= `MIC_RST_BYTE;
		end else begin
			if (take) begin
				core_reg <= core_reg & ~`MIC_MSK_CORE;
			end else if (wr_fire && wstrb0_reg && awaddr_reg == `MIC_OFS_CORE) begin
				core_reg <= wdata_reg & `MIC_MSK_CORE;
			end
			ext_reg <= upd(ext_reg, wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_EXT),
				wdata_reg, `MIC_MSK_EXT, ext_set, ext_clr);
			if (wr_fire && wstrb0_reg && awaddr_reg == `MIC_OFS_EDGE) begin
				edge_reg <= wdata_reg;
			end
			cmp_reg <= upd(cmp_reg, wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_CMP),
				wdata_reg, `MIC_MSK_CMP, cmp_set, cmp_clr);
			if (wr_fire && wstrb0_reg && awaddr_reg == `MIC_OFS_TM1B) begin
				tm1_reg <= upd(tm1_reg, 1'b1,
					(wdata_reg & `MIC_MSK_TM1B) | (tm1_reg & ~`MIC_MSK_TM1B),
					`MIC_MSK_TM1X, tm1_set, 8'h00);
			end else begin
				tm1_reg <= upd(tm1_reg,
					wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_TM1X),
					wdata_reg, `MIC_MSK_TM1X, tm1_set, 8'h00);
			end
			per_reg <= upd(per_reg, wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_PER),
				wdata_reg, `MIC_MSK_PER, per_set, 8'h00);
			tm3_reg <= upd(tm3_reg, wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_TM3),
				wdata_reg, `MIC_MSK_TM3, tm3_set, 8'h00);
			mf_reg <= upd(mf_reg, wr_fire & wstrb0_reg & (awaddr_reg == `MIC_OFS_MF),
				wdata_reg, `MIC_MSK_MF, mf_set, mf_clr);
			if (wr_fire && wstrb0_reg && awaddr_reg == `MIC_OFS_PULL) begin
				pull_reg <= wdata_reg & `MIC_MSK_PULL;
			end
		end
	end

	// Pull-high choice passes straight out, untouched by interrupt use
	assign PULLUP_EN = pull_reg[3:0];

	// Core sequencing: push next address, present vector, pop on return
	always @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			take_reg <= 1'b0;
			vector_reg <= {`MIC_PC_W{1'b0}};
			push_data_reg <= {`MIC_PC_W{1'b0}};
			pop_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			take_reg <= take;
			if (take) begin
				push_data_reg <= PC_NEXT;
				vector_reg <= vec_of(idx);
			end
			pop_reg <= RETURN_FROM_INTERRUPT;
			wake_reg <= LOW_POWER & new_flag;
		end
	end

	assign IRQ_TAKE = take_reg;
	assign PUSH_PC = take_reg;
	assign VECTOR_ADDR = vector_reg;
	assign PUSH_DATA = push_data_reg;
	assign POP_PC = pop_reg;
	assign WAKE_UP = wake_reg;

	// Write channels: address and data may arrive in either order
	always @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= {`MIC_AW{1'b0}};
			w_hold_reg <= 1'b0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `MIC_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA[7:0];
				wstrb0_reg <= S_AXI_WSTRB[0];
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= mapped(awaddr_reg) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
			end else if (bvalid_reg && S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// One outstanding write; channels stall until the response is taken
	assign S_AXI_AWREADY = ~aw_hold_reg & ~bvalid_reg;
	assign S_AXI_WREADY = ~w_hold_reg & ~bvalid_reg;
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_reg;

	// Read mux; unimplemented bits come back as zero through the masks
	always @* begin
		rd_mux = 32'h0000_0000;
		case (S_AXI_ARADDR)
			`MIC_OFS_CORE: rd_mux[7:0] = core_reg;
			`MIC_OFS_EXT: rd_mux[7:0] = ext_reg;
			`MIC_OFS_EDGE: rd_mux[7:0] = edge_reg;
			`MIC_OFS_CMP: rd_mux[7:0] = cmp_reg;
			`MIC_OFS_TM1X: rd_mux[7:0] = tm1_reg;
			`MIC_OFS_TM1B: rd_mux[7:0] = tm1_reg & `MIC_MSK_TM1B;
			`MIC_OFS_PER: rd_mux[7:0] = per_reg;
			`MIC_OFS_TM3: rd_mux[7:0] = tm3_reg;
			`MIC_OFS_MF: rd_mux[7:0] = mf_reg;
			`MIC_OFS_PULL: rd_mux[7:0] = pull_reg;
			`MIC_OFS_STAT: rd_mux[15:0] = {idx, 2'b00, hit, pend};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read channel: data registered, held until taken
	always @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `MIC_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= mapped(S_AXI_ARADDR) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
			end else if (rvalid_reg && S_AXI_RREADY) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign S_AXI_ARREADY = ~rvalid_reg;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_reg;
endmodule

// File: mic_core_model.sv
// Behavioural core model: program counter, call stack and return sequencing
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_core_model #(
	parameter DEPTH = 2
) (
	input wire clk,
	input wire rst_n,
	input wire take,
	input wire [`MIC_PC_W-1:0] vec,
	input wire [`MIC_PC_W-1:0] push_data,
	input wire pop,
	input wire ret_cmd,
	output reg [`MIC_PC_W-1:0] pc_reg,
	output wire full,
	output reg slot_reg,
	output reg ret_reg
);
	logic [`MIC_PC_W-1:0] stk[$];
	integer depth_reg;
	// Full stack withholds acceptance; DEPTH pushes fill it, a pop frees one
	assign full = (depth_reg >= DEPTH);
	// Slot only every other cycle, so the controller also meets a busy core
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= 13'h0100;
			slot_reg <= 1'b0;
			ret_reg <= 1'b0;
			depth_reg <= 0;
			stk.delete();
		end else begin
			slot_reg <= ~slot_reg;
			ret_reg <= ret_cmd;
			pc_reg <= pc_reg + 13'h0001;
			if (take) begin
				stk.push_back(push_data);
				depth_reg <= depth_reg + 1;
				pc_reg <= vec;
			end else if (pop && stk.size() > 0) begin
				depth_reg <= depth_reg - 1;
				pc_reg <= stk.pop_back();
			end
		end
	end
endmodule

// File: mic_top_chk.sv
// Port-level assertions on the core handshake of the interrupt controller
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_top_chk (
	input wire MCLK,
	input wire ARST_N,
	input wire [`MIC_PC_W-1:0] PC_NEXT,
	input wire STACK_FULL,
	input wire ACCEPT_SLOT,
	input wire RETURN_FROM_INTERRUPT,
	input wire LOW_POWER,
	input wire IRQ_TAKE,
	input wire [`MIC_PC_W-1:0] VECTOR_ADDR,
	input wire PUSH_PC,
	input wire [`MIC_PC_W-1:0] PUSH_DATA,
	input wire POP_PC,
	input wire WAKE_UP
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	// Acceptance and its answer
	chk_take_cause: assert property (IRQ_TAKE |-> !$past(STACK_FULL) && $past(ACCEPT_SLOT))
		else $error("take without free stack and slot");
	chk_no_nest: assert property (IRQ_TAKE |=> !IRQ_TAKE)
		else $error("second take right after a take");
	chk_push_data: assert property (IRQ_TAKE |-> PUSH_PC && PUSH_DATA == $past(PC_NEXT))
		else $error("push missing or wrong address");
	chk_vec_legal: assert property (IRQ_TAKE |-> VECTOR_ADDR[1:0] == 2'h0 && VECTOR_ADDR >= 13'h0004 && VECTOR_ADDR <= 13'h0024)
		else $error("vector outside the table");
	chk_vec_stable: assert property (!IRQ_TAKE |-> $stable(VECTOR_ADDR))
		else $error("vector moved without a take");
	// Return and wake
	chk_pop_follow: assert property (RETURN_FROM_INTERRUPT |=> POP_PC)
		else $error("return without pop");
	chk_pop_cause: assert property (POP_PC |-> $past(RETURN_FROM_INTERRUPT))
		else $error("pop without return");
	chk_wake_cause: assert property (WAKE_UP |-> $past(LOW_POWER))
		else $error("wake outside low power");
	cover property (IRQ_TAKE);
	cover property (POP_PC);
	cover property (WAKE_UP);
endmodule

// File: test_mcu_interrupt_controller.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "mic_defs.vh"
module test_mcu_interrupt_controller;
	reg mclk, arst_n, awv, wv, bready, arv, rready, cmp0, cmp1, low_power, ret_cmd;
	reg [7:0] awaddr, araddr, ev;
	reg [31:0] wdata, d;
	reg [3:0] pins, dir;
	reg xpin;
	wire awready, wready, bvalid, arready, rvalid, take, push, pop, wake, full, slot, ret;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [12:0] vec, pdata, pc;
	wire [3:0] pull;
	integer error_cnt = 0, checks = 0, takes = 0, wakes = 0, tk = 0, i, m, r;
	mic_top dut_u (.MCLK(mclk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_IRQ_PINS(pins),
		.PORT_DIR_IN(dir), .EXT_PERIPH_PIN(xpin), .CMP0_OUT(cmp0), .CMP1_OUT(cmp1),
		.TM1_CMPA_EVT(ev[0]), .TM1_CMPP_EVT(ev[1]), .TM1_CMPB_EVT(ev[2]), .TM3_CMPA_EVT(ev[3]),
		.TM3_CMPP_EVT(ev[4]), .EEPROM_EVT(ev[5]), .LOW_VOLT_EVT(ev[6]), .SERIAL_EVT(ev[7]),
		.PC_NEXT(pc), .STACK_FULL(full), .ACCEPT_SLOT(slot), .RETURN_FROM_INTERRUPT(ret),
		.LOW_POWER(low_power), .IRQ_TAKE(take), .VECTOR_ADDR(vec), .PUSH_PC(push),
		.PUSH_DATA(pdata), .POP_PC(pop), .WAKE_UP(wake), .PULLUP_EN(pull));
	mic_core_model core_u (.clk(mclk), .rst_n(arst_n), .take(take), .vec(vec),
		.push_data(pdata), .pop(pop), .ret_cmd(ret_cmd), .pc_reg(pc), .full(full),
		.slot_reg(slot), .ret_reg(ret));
	// Clock, 8 ns period
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Pulse tallies, so waits can ask whether one came
	always @(posedge mclk) begin
		if (take) takes <= takes + 1;
		if (wake) wakes <= wakes + 1;
	end
	task stop_test;
		begin
			$display("mismatches %0d comparisons %0d", error_cnt, checks);
			if (error_cnt == 0 && checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			checks++;
			if (seen !== exp) begin
				error_cnt++;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task tmo;
		begin
			error_cnt++;
			stop_test;
		end
	endtask
	// Handshakes judged at the rising edge; ready signals stay high between transfers
	task axw(input [7:0] a, input [7:0] dd, input [1:0] er);
		integer n;
		reg ra, rw, rb;
		reg [1:0] br;
		begin
			awaddr <= a;
			wdata <= {24'h0000_00, dd};
			awv <= 1'b1;
			wv <= 1'b1;
			bready <= 1'b1;
			rb = 1'b0;
			for (n = 0; n < 40 && !rb; n++) begin
				@(posedge mclk);
				ra = awv & awready;
				rw = wv & wready;
				rb = bvalid;
				br = bresp;
				if (ra) awv <= 1'b0;
				if (rw) wv <= 1'b0;
			end
			if (!rb) tmo;
			chk(br, er);
		end
	endtask
	task axr(input [7:0] a, input [7:0] e, input [1:0] er);
		integer n;
		reg ra, rv;
		reg [31:0] rd;
		reg [1:0] rr;
		begin
			araddr <= a;
			arv <= 1'b1;
			rready <= 1'b1;
			rv = 1'b0;
			for (n = 0; n < 40 && !rv; n++) begin
				@(posedge mclk);
				ra = arv & arready;
				rv = rvalid;
				rd = rdata;
				rr = rresp;
				if (ra) arv <= 1'b0;
			end
			if (!rv) tmo;
			chk(rd, {24'h0000_00, e});
			chk(rr, er);
		end
	endtask
	// Expected take count kept by the bench, so a take before the wait is not missed
	task wt(input [12:0] e);
		integer k;
		begin
			tk = tk + 1;
			for (k = 0; k < 40 && takes < tk; k++) @(posedge mclk);
			if (takes < tk) tmo;
			chk(takes, tk);
			chk(vec, e);
		end
	endtask
	task nt;
		begin
			repeat (12) @(posedge mclk);
			chk(takes, tk);
		end
	endtask
	task pulse(input integer k);
		begin
			ev[k] <= 1'b1;
			@(posedge mclk);
			ev[k] <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask
	task do_ret;
		begin
			ret_cmd <= 1'b1;
			@(posedge mclk);
			ret_cmd <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask
	// Hang guard
	initial begin
		repeat (50000) @(posedge mclk);
		tmo;
	end
	// Main sequence
	initial begin
		arst_n = 1'b0; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
		cmp0 = 1'b0; cmp1 = 1'b0; low_power = 1'b0; ret_cmd = 1'b0; awaddr = 8'h00;
		araddr = 8'h00; wdata = 32'h0000_0000; pins = 4'h0; ev = 8'h00;
		dir = 4'hF; xpin = 1'b1;
		r = $urandom(32'h1202);
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		for (i = 0; i <= 36; i += 4) axr(i[7:0], 8'h00, `MIC_RESP_OKAY);
		axr(8'h2C, 8'h00, `MIC_RESP_SLVERR);
		axw(8'h2C, 8'h01, `MIC_RESP_SLVERR);
		axw(`MIC_OFS_TM1B, 8'hFF, `MIC_RESP_OKAY);
		axr(`MIC_OFS_TM1X, 8'h33, `MIC_RESP_OKAY);
		axw(`MIC_OFS_TM1X, 8'hFF, `MIC_RESP_OKAY);
		axr(`MIC_OFS_TM1X, 8'h77, `MIC_RESP_OKAY);
		axw(`MIC_OFS_TM3, 8'hFF, `MIC_RESP_OKAY);
		axr(`MIC_OFS_TM3, 8'h33, `MIC_RESP_OKAY);
		axw(`MIC_OFS_PER, 8'hFF, `MIC_RESP_OKAY);
		axr(`MIC_OFS_PER, 8'hFF, `MIC_RESP_OKAY);
		axw(`MIC_OFS_TM1X, 8'h00, `MIC_RESP_OKAY);
		axw(`MIC_OFS_TM3, 8'h00, `MIC_RESP_OKAY);
		axw(`MIC_OFS_PER, 8'h00, `MIC_RESP_OKAY);
		// Random pull-high selections reach the pins
		for (i = 0; i < 3; i++) begin
			d = $urandom;
			axw(`MIC_OFS_PULL, d[7:0], `MIC_RESP_OKAY);
			chk(pull, d[3:0]);
		end
		// Every edge code on pin 0, global enable still off
		axw(`MIC_OFS_EXT, 8'h0F, `MIC_RESP_OKAY);
		for (m = 0; m < 4; m++) begin
			axw(`MIC_OFS_EDGE, m[7:0], `MIC_RESP_OKAY);
			pins[0] <= 1'b1;
			repeat (6) @(posedge mclk);
			axr(`MIC_OFS_EXT, m[0] ? 8'h1F : 8'h0F, `MIC_RESP_OKAY);
			axw(`MIC_OFS_EXT, 8'h0F, `MIC_RESP_OKAY);
			pins[0] <= 1'b0;
			repeat (6) @(posedge mclk);
			axr(`MIC_OFS_EXT, m[1] ? 8'h1F : 8'h0F, `MIC_RESP_OKAY);
			axw(`MIC_OFS_EXT, 8'h0F, `MIC_RESP_OKAY);
		end
		// Pin set as output: both edges ignored
		dir <= 4'hE;
		pins[0] <= 1'b1;
		repeat (6) @(posedge mclk);
		pins[0] <= 1'b0;
		repeat (6) @(posedge mclk);
		axr(`MIC_OFS_EXT, 8'h0F, `MIC_RESP_OKAY);
		dir <= 4'hF;
		// Two pins at once: priority, auto clear, no nesting
		axw(`MIC_OFS_EDGE, 8'hFF, `MIC_RESP_OKAY);
		pins <= 4'hA;
		repeat (6) @(posedge mclk);
		axw(`MIC_OFS_CORE, 8'h01, `MIC_RESP_OKAY);
		wt(13'h0008);
		axr(`MIC_OFS_EXT, 8'h8F, `MIC_RESP_OKAY);
		axr(`MIC_OFS_CORE, 8'h00, `MIC_RESP_OKAY);
		axw(`MIC_OFS_CORE, 8'h01, `MIC_RESP_OKAY);
		wt(13'h0010);
		// Comparator held while blocked, then behind a full stack
		axw(`MIC_OFS_CMP, 8'h02, `MIC_RESP_OKAY);
		cmp1 <= 1'b1;
		nt;
		axr(`MIC_OFS_CMP, 8'h22, `MIC_RESP_OKAY);
		axw(`MIC_OFS_CORE, 8'h01, `MIC_RESP_OKAY);
		nt;
		do_ret;
		wt(13'h0018);
		axr(`MIC_OFS_CMP, 8'h02, `MIC_RESP_OKAY);
		do_ret;
		do_ret;
		// Grouped source: off enable keeps the group quiet
		axw(`MIC_OFS_MF, 8'h07, `MIC_RESP_OKAY);
		axw(`MIC_OFS_CORE, 8'h01, `MIC_RESP_OKAY);
		pulse(3);
		axr(`MIC_OFS_TM3, 8'h20, `MIC_RESP_OKAY);
		nt;
		axw(`MIC_OFS_TM3, 8'h22, `MIC_RESP_OKAY);
		pulse(3);
		wt(13'h0024);
		axr(`MIC_OFS_TM3, 8'h22, `MIC_RESP_OKAY);
		axr(`MIC_OFS_MF, 8'h07, `MIC_RESP_OKAY);
		// Wake only on a fresh flag
		low_power <= 1'b1;
		r = wakes;
		pulse(5);
		chk(wakes, r + 1);
		pulse(5);
		chk(wakes, r + 1);
		low_power <= 1'b0;
		// Falling edge on the external peripheral pin sets its flag in the peripheral group register
		xpin <= 1'b0;
		repeat (6) @(posedge mclk);
		axr(`MIC_OFS_PER, 8'hA0, `MIC_RESP_OKAY);
		stop_test;
	end
endmodule
bind mic_top mic_top_chk chk_u (.MCLK(MCLK), .ARST_N(ARST_N), .PC_NEXT(PC_NEXT),
	.STACK_FULL(STACK_FULL), .ACCEPT_SLOT(ACCEPT_SLOT),
	.RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT), .LOW_POWER(LOW_POWER), .IRQ_TAKE(IRQ_TAKE),
	.VECTOR_ADDR(VECTOR_ADDR), .PUSH_PC(PUSH_PC), .PUSH_DATA(PUSH_DATA), .POP_PC(POP_PC),
	.WAKE_UP(WAKE_UP));
